// ===== bench/rtrig_regs_props.sv
// Bus and output checks for the result and trigger register bank
`timescale 1ns/1ps
`default_nettype none
module rtrig_regs_props (
  input wire logic                MCLK,
  input wire logic                RST_N,
  input wire logic                PSEL,
  input wire logic                PENABLE,
  input wire logic                PWRITE,
  input wire logic [11:0]         PADDR,
  input wire logic [31:0]         PWDATA,
  input wire logic [31:0]         PRDATA,
  input wire logic                PREADY,
  input wire logic                PSLVERR,
  input wire rtrig_pkg::result_s  RESULT,
  input wire logic [7:0]          ALERTS,
  input wire logic [4:0]          DOUT
);
  import rtrig_pkg::*;
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  ready_after_setup_a: assert property (PSEL && !PENABLE |=> PREADY)
    else $error("no ready after setup");
  ready_single_a: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  upper_zero_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0)
    else $error("read data above byte");
  idle_rdata_a: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside access");
  misalign_err_a: assert property (PREADY && PADDR[1:0] != 2'h0 |-> PSLVERR)
    else $error("misaligned access not refused");
  err_with_ready_a: assert property (PSLVERR |-> PREADY)
    else $error("error without ready");
  ro_write_a: assert property (
    PREADY && PWRITE && PADDR == {2'h0, IDX_CH7_UPPER, 2'h0} |-> !PSLVERR)
    else $error("result write refused");
  // Sync delay is two flops plus the output flop
  dout_cause_a: assert property ($changed(DOUT) |->
    $past(ALERTS, 2) != 8'h0 || $past(ALERTS, 3) != 8'h0 || $past(ALERTS, 4) != 8'h0)
    else $error("output moved without alert");
  wr_c: cover property (PREADY && PWRITE);
  err_c: cover property (PSLVERR);
  dout_c: cover property ($rose(DOUT[0]));
endmodule : rtrig_regs_props
bind rtrig_regs rtrig_regs_props u_rtrig_regs_props (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
  .PREADY(PREADY), .PSLVERR(PSLVERR), .RESULT(RESULT), .ALERTS(ALERTS), .DOUT(DOUT));
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for the result and trigger register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
  import rtrig_pkg::*;
  localparam logic [7:0] MAP [8] = '{IDX_CH6_UPPER, IDX_CH7_LOWER, IDX_CH7_UPPER,
    IDX_OUT0_SEL, IDX_OUT1_SEL, IDX_OUT2_SEL, IDX_OUT3_SEL, IDX_OUT4_SEL};
  logic        MCLK, RST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, er;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, rd;
  result_s     RESULT;
  logic [7:0]  ALERTS;
  logic [4:0]  DOUT;
  int          errors, n_compared;
  rtrig_regs u_rtrig_regs (.MCLK(MCLK), .RST_N(RST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .RESULT(RESULT), .ALERTS(ALERTS), .DOUT(DOUT));
  initial begin
    MCLK = 1'b0;
    forever #5 MCLK = ~MCLK;
  end
  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // One transfer, then an idle cycle so the next setup never lands in the same step
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d,
                     input logic [1:0] lo = 2'h0);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= {2'h0, idx, lo};
    PWDATA <= {24'h0, d};
    @(posedge MCLK);
    PENABLE <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 8);
    if (PREADY !== 1'b1) begin
      errors++;
      $display("wrong value at %0t: no ready from slave", $time);
      tally_and_finish;
    end
    rd = PRDATA;
    er = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge MCLK);
  endtask : apb
  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, MAP[i], 8'h0);
      cmp(rd, (i < 3) ? 32'h0 : 32'h2);
    end
    $display("reset values done");
  endtask : t_reset
  task automatic t_rw;
    for (int i = 3; i < 8; i++) apb(1'b1, MAP[i], 8'h81 + 8'(i));
    apb(1'b1, MAP[0], 8'hff);
    apb(1'b1, MAP[2], 8'hff);
    for (int i = 0; i < 8; i++) begin
      apb(1'b0, MAP[i], 8'h0);
      cmp(rd, (i < 3) ? 32'h0 : 32'h81 + i);
    end
    apb(1'b0, 8'hc4, 8'h0);
    cmp(er, 32'h1);
    // Misaligned accesses are refused and a misaligned write changes nothing
    apb(1'b0, IDX_OUT0_SEL, 8'h0, 2'h1);
    cmp(er, 32'h1);
    apb(1'b1, IDX_OUT0_SEL, 8'h55, 2'h2);
    apb(1'b0, IDX_OUT0_SEL, 8'h0);
    cmp(rd, 32'h84);
    $display("read write done");
  endtask : t_rw
  task automatic t_result;
    RESULT <= '{1'b1, 1'b0, 16'hab12};
    @(posedge MCLK);
    RESULT <= '{1'b1, 1'b1, 16'hc3d4};
    @(posedge MCLK);
    RESULT.valid <= 1'b0;
    @(posedge MCLK);
    apb(1'b0, MAP[0], 8'h0);
    cmp(rd, 32'hab);
    apb(1'b0, MAP[1], 8'h0);
    cmp(rd, 32'hd4);
    apb(1'b0, MAP[2], 8'h0);
    cmp(rd, 32'hc3);
    $display("results done");
  endtask : t_result
  task automatic t_alert;
    apb(1'b1, IDX_OUT0_SEL, 8'h08);
    apb(1'b1, IDX_OUT1_SEL, 8'hf7);
    apb(1'b1, IDX_TRIG_LEVEL, 8'h03);
    apb(1'b1, IDX_TRIG_EN, 8'h03);
    ALERTS <= 8'h08;
    repeat (5) @(posedge MCLK);
    cmp(DOUT, 32'h1);
    apb(1'b1, IDX_TRIG_EN, 8'h00);
    apb(1'b1, IDX_TRIG_LEVEL, 8'h00);
    repeat (5) @(posedge MCLK);
    cmp(DOUT, 32'h1);
    // Level zero with the alert still standing drives output 0 low
    apb(1'b1, IDX_TRIG_EN, 8'h01);
    repeat (5) @(posedge MCLK);
    cmp(DOUT, 32'h0);
    $display("alerts done");
  endtask : t_alert
  initial begin
    {RST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, RESULT, ALERTS} = '0;
    repeat (4) @(posedge MCLK);
    RST_N <= 1'b1;
    repeat (3) @(posedge MCLK);
    t_reset;
    t_rw;
    t_result;
    t_alert;
    tally_and_finish;
  end
endmodule : tb
`default_nettype wire

// ===== core/rtrig_out_slice.sv
// One digital output driven by its selected alert flags
`timescale 1ns/1ps
`default_nettype none
module rtrig_out_slice (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] alerts,
  input  wire logic [7:0] sel,
  input  wire logic       en,
  input  wire logic       level,
  output logic            pin
);
  logic hit;

  // Unselected channels are masked off
  assign hit = |(alerts & sel);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin <= 1'b0;
    end else if (hit && en) begin
      pin <= level;
    end
  end
endmodule : rtrig_out_slice
`default_nettype wire

// ===== core/rtrig_pkg.sv
// Register map, reset values and carrier types for the result and trigger block
package rtrig_pkg;

  // Printed offsets are not word multiples: these are indices, byte address = 4 * index
  localparam logic [7:0] IDX_CH6_UPPER  = 8'had;
  localparam logic [7:0] IDX_CH7_LOWER  = 8'hae;
  localparam logic [7:0] IDX_CH7_UPPER  = 8'haf;
  localparam logic [7:0] IDX_OUT0_SEL   = 8'hc3;
  localparam logic [7:0] IDX_OUT1_SEL   = 8'hc5;
  localparam logic [7:0] IDX_OUT2_SEL   = 8'hc7;
  localparam logic [7:0] IDX_OUT3_SEL   = 8'hc9;
  localparam logic [7:0] IDX_OUT4_SEL   = 8'hcb;
  // Offsets of own choosing for the enable and level fields
  localparam logic [7:0] IDX_TRIG_EN    = 8'he9;
  localparam logic [7:0] IDX_TRIG_LEVEL = 8'heb;

  localparam int         NUM_OUT        = 5;
  localparam int         NUM_CH         = 8;
  localparam logic [7:0] SEL_RESET      = 8'h02;
  localparam logic [7:0] RESULT_RESET   = 8'h00;
  localparam logic [7:0] EN_RESET       = 8'h00;
  localparam logic [7:0] LEVEL_RESET    = 8'h00;
  localparam logic [4:0] OUT_RESET      = 5'h00;
  localparam logic [1:0] SYNC_RESET     = 2'h0;

  // One finished conversion delivered by the converter core
  typedef struct packed {
    logic        valid;
    logic        channel;   // 0: channel 6, 1: channel 7
    logic [15:0] value;     // Result, MSB aligned
  } result_s;

endpackage : rtrig_pkg

// ===== core/rtrig_regs.sv
// APB register bank: recent results and per-output alert trigger selection
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`default_nettype none
module rtrig_regs (
  // Clock and reset
  input  wire logic                 MCLK,
  input  wire logic                 RST_N,
  // APB slave
  input  wire logic                 PSEL,
  input  wire logic                 PENABLE,
  input  wire logic                 PWRITE,
  input  wire logic [11:0]          PADDR,
  input  wire logic [31:0]          PWDATA,
  output logic [31:0]               PRDATA,
  output logic                      PREADY,
  output logic                      PSLVERR,
  // Converter core, same clock
  input  wire rtrig_pkg::result_s   RESULT,
  // Alert flags per channel, asynchronous
  input  wire logic [7:0]           ALERTS,
  // Digital outputs 0..4
  output logic [4:0]                DOUT
);
  import rtrig_pkg::*;

  logic [1:0]  rst_sync_r;
  logic        rst_n;
  logic [7:0]  ch6_result_upper_r;
  logic [7:0]  ch7_result_lower_r;
  logic [7:0]  ch7_result_upper_r;
  logic [7:0]  sel_r [NUM_OUT];
  logic [7:0]  triggered_update_enable_r;
  logic [7:0]  level_on_trigger_r;
  logic [7:0]  alerts_s;
  logic [4:0]  dout_w;
  logic        setup;
  logic        wr_ok;
  logic        word_ok;
  logic [7:0]  idx;
  logic        hit;
  logic [7:0]  rdata;

  // Reset release through two flops
  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_r <= SYNC_RESET;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_sync
      rtrig_sync u_sync (
        .clk   (MCLK),
        .rst_n (rst_n),
        .d     (ALERTS[g]),
        .q     (alerts_s[g])
      );
    end
    for (g = 0; g < NUM_OUT; g++) begin : g_out
      rtrig_out_slice u_slice (
        .clk    (MCLK),
        .rst_n  (rst_n),
        .alerts (alerts_s),
        .sel    (sel_r[g]),
        .en     (triggered_update_enable_r[g]),
        .level  (level_on_trigger_r[g]),
        .pin    (dout_w[g])
      );
    end
  endgenerate
  assign DOUT = dout_w;

  // Latest conversion results
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ch6_result_upper_r <= RESULT_RESET;
      ch7_result_lower_r <= RESULT_RESET;
      ch7_result_upper_r <= RESULT_RESET;
    end else if (RESULT.valid) begin
      if (RESULT.channel) begin
        ch7_result_upper_r <= RESULT.value[15:8];
        ch7_result_lower_r <= RESULT.value[7:0];
      end else begin
        ch6_result_upper_r <= RESULT.value[15:8];
      end
    end
  end

  // APB decode; one wait-free access phase
  assign setup   = PSEL && !PENABLE;
  assign word_ok = (PADDR[1:0] == 2'h0);
  assign idx     = PADDR[9:2];
  assign wr_ok   = PSEL && PENABLE && PWRITE && word_ok && (PADDR[11:10] == 2'h0);

  always_comb begin
    hit   = 1'b1;
    rdata = 8'h00;
    case (idx)
      IDX_CH6_UPPER:  rdata = ch6_result_upper_r;
      IDX_CH7_LOWER:  rdata = ch7_result_lower_r;
      IDX_CH7_UPPER:  rdata = ch7_result_upper_r;
      IDX_OUT0_SEL:   rdata = sel_r[0];
      IDX_OUT1_SEL:   rdata = sel_r[1];
      IDX_OUT2_SEL:   rdata = sel_r[2];
      IDX_OUT3_SEL:   rdata = sel_r[3];
      IDX_OUT4_SEL:   rdata = sel_r[4];
      IDX_TRIG_EN:    rdata = triggered_update_enable_r;
      IDX_TRIG_LEVEL: rdata = level_on_trigger_r;
      default:        hit   = 1'b0;
    endcase
    if (!word_ok || PADDR[11:10] != 2'h0) begin
      hit = 1'b0;
    end
  end

  // Writable selection and trigger fields
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_OUT; i++) begin
        sel_r[i] <= SEL_RESET;
      end
      triggered_update_enable_r <= EN_RESET;
      level_on_trigger_r        <= LEVEL_RESET;
    end else if (wr_ok) begin
      // Result indices fall through: writes there change nothing
      case (idx)
        IDX_OUT0_SEL:   sel_r[0] <= PWDATA[7:0];
        IDX_OUT1_SEL:   sel_r[1] <= PWDATA[7:0];
        IDX_OUT2_SEL:   sel_r[2] <= PWDATA[7:0];
        IDX_OUT3_SEL:   sel_r[3] <= PWDATA[7:0];
        IDX_OUT4_SEL:   sel_r[4] <= PWDATA[7:0];
        IDX_TRIG_EN:    triggered_update_enable_r <= PWDATA[7:0];
        IDX_TRIG_LEVEL: level_on_trigger_r        <= PWDATA[7:0];
        default:        ;
      endcase
    end
  end

  // Answer registered in setup, so access phase completes at its first edge
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (setup) begin
      PRDATA  <= (hit && !PWRITE) ? {24'h00_0000, rdata} : 32'h0000_0000;
      PREADY  <= 1'b1;
      PSLVERR <= !hit;
    end else begin
      PRDATA  <= 32'h0000_0000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end
endmodule : rtrig_regs
`default_nettype wire

// ===== core/rtrig_sync.sv
// Two-flop synchroniser for one level
`timescale 1ns/1ps
`default_nettype none
module rtrig_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic d,
  output logic      q
);
  logic meta_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q      <= 1'b0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : rtrig_sync
`default_nettype wire
